// file: buck_seq_defs.svh
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH

// Clock and switching timing.
`define CLK_PERIOD_NS 50
`define OSC_PERIOD_NS 500
`define NOM_PERIOD_CYC (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define STRETCH_FACTOR 4
`define MIN_ON_NS 70
`define MIN_ON_CYC ((`MIN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_OFF_NS 120
`define MIN_OFF_CYC ((`MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Output monitor filter and release delay.
`define FILTER_US 15
`define FILTER_CYC ((`FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_US 120
`define RELEASE_CYC ((`RELEASE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Soft start and hiccup hold-off.
`define SS_US 500
`define SS_CYC ((`SS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HICCUP_MS 7
`define HICCUP_CYC ((`HICCUP_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Register byte addresses.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_PERIOD 12'h008

// Control register fields.
`define CTRL_DEMAND_LSB 0
`define CTRL_DEMAND_W 8
`define CTRL_LATCH_BIT 8
`define CTRL_RESET_DEMAND 8'h00

`endif

// file: buck_seq_pkg.sv
package buck_seq_pkg;

  // Sequencer states, Gray coded along off, soft, run, hiccup.
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_SOFT = 3'h1,
    ST_RUN = 3'h3,
    ST_HICCUP = 3'h2,
    ST_LATCH = 3'h6
  } seq_state_t;

endpackage : buck_seq_pkg

// file: qual_if.sv
`timescale 1ns/1ps
interface qual_if;
  logic raw;
  logic det;
  modport timer (input raw, output det);
  modport user (output raw, input det);
endinterface : qual_if

// file: qual_timer.sv
`timescale 1ns/1ps
`include "buck_seq_defs.svh"
module qual_timer #(
  parameter int DETECT_CYC = `FILTER_CYC,
  parameter int RELEASE_CYC = `RELEASE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  qual_if.timer q
);
  localparam int CW = $clog2(DETECT_CYC + RELEASE_CYC + 1);
  localparam logic [CW-1:0] DET_LAST = CW'(DETECT_CYC - 1);
  localparam logic [CW-1:0] REL_LAST = CW'(RELEASE_CYC - 1);

  logic [CW-1:0] cnt;

  // The flag follows the raw level only after it has held unbroken for
  // the whole interval; any glitch back restarts the count.
  // restartable interval counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      q.det <= 1'b0;
    end else if (q.raw == q.det) begin
      cnt <= '0;
    end else if (cnt == (q.det ? REL_LAST : DET_LAST)) begin
      cnt <= '0;
      q.det <= q.raw;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule : qual_timer

// file: buck_seq_top.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "buck_seq_defs.svh"
module buck_seq_top #(
  parameter int NOM_PERIOD = `NOM_PERIOD_CYC,
  parameter int SS_CYCLES = `SS_CYC,
  parameter int HICCUP_CYCLES = `HICCUP_CYC,
  parameter int FILTER_CYCLES = `FILTER_CYC,
  parameter int RELEASE_CYCLES = `RELEASE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low_lockout,
  input wire logic input_high_lockout,
  input wire logic enable_high,
  input wire logic thermal_shutdown,
  input wire logic output_over_detect,
  input wire logic output_under_detect,
  input wire logic current_limit,
  output logic high_side_on,
  output logic low_side_on,
  input wire logic output_ok_flag_in,
  output logic output_ok_flag_out,
  output logic output_ok_flag_oe_n
);
  localparam int PW = 8;
  localparam int NSYNC = 8;
  localparam int SCW = $clog2(SS_CYCLES + 1);
  localparam int HCW = $clog2(HICCUP_CYCLES + 1);
  localparam logic [PW-1:0] NOM = PW'(NOM_PERIOD);
  localparam logic [PW-1:0] STRETCH_MAX = PW'((`STRETCH_FACTOR - 1) * NOM_PERIOD);
  localparam logic [PW-1:0] MIN_ON = PW'(`MIN_ON_CYC);
  localparam logic [PW-1:0] MIN_OFF = PW'(`MIN_OFF_CYC);
  localparam logic [SCW-1:0] SS_LAST = SCW'(SS_CYCLES - 1);
  localparam logic [HCW-1:0] HIC_LAST = HCW'(HICCUP_CYCLES - 1);
  // Positions inside the synchroniser bundle.
  localparam int I_SUPPLY = 0;
  localparam int I_INPUT = 1;
  localparam int I_ENABLE = 2;
  localparam int I_THERMAL = 3;
  localparam int I_OVER = 4;
  localparam int I_UNDER = 5;
  localparam int I_LIMIT = 6;
  localparam int I_PGPIN = 7;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic supply_low_s;
  logic input_high_s;
  logic enable_s;
  logic thermal_s;
  logic over_s;
  logic limit_s;
  logic stop_all;
  logic fault_trip;
  logic switching;
  buck_seq_pkg::seq_state_t state;
  logic [SCW-1:0] ss_cnt;
  logic [HCW-1:0] hic_cnt;
  logic [PW-1:0] demand;
  logic latch_mode;
  logic [PW-1:0] ramp;
  logic [PW-1:0] eff_demand;
  logic [PW-1:0] stretch;
  logic [PW-1:0] cur_period;
  logic [PW-1:0] max_on;
  logic [PW-1:0] on_len;
  logic off_cut;
  logic [PW-1:0] pcnt;
  logic [PW-1:0] cyc_on;
  logic [PW-1:0] cur_on;
  logic period_end;
  logic power_fault;
  logic setup_phase;
  logic wr_access;
  logic addr_ok;
  logic [31:0] next_rdata;

  qual_if over_q ();
  qual_if under_q ();

  // Every comparator flag and the sensed power-good pin are asynchronous
  // to the oscillator, so each passes two flops before use.
  assign pin_raw = {output_ok_flag_in, current_limit, output_under_detect,
                    output_over_detect, thermal_shutdown, enable_high,
                    input_high_lockout, supply_low_lockout};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  assign supply_low_s = sync2[I_SUPPLY];
  assign input_high_s = sync2[I_INPUT];
  assign enable_s = sync2[I_ENABLE];
  assign thermal_s = sync2[I_THERMAL];
  assign over_s = sync2[I_OVER];
  assign limit_s = sync2[I_LIMIT];

  // Output monitors: filtered detection with a longer release delay.
  // detection filters
  assign over_q.raw = over_s;
  assign under_q.raw = sync2[I_UNDER];

  qual_timer #(
    .DETECT_CYC(FILTER_CYCLES),
    .RELEASE_CYC(RELEASE_CYCLES)
  ) u_over (
    .pclk(pclk),
    .presetn(presetn),
    .q(over_q.timer)
  );

  qual_timer #(
    .DETECT_CYC(FILTER_CYCLES),
    .RELEASE_CYC(RELEASE_CYCLES)
  ) u_under (
    .pclk(pclk),
    .presetn(presetn),
    .q(under_q.timer)
  );

  // Any of these stops switching; only supply-low lockout or enable low clears a
  // latched trip, and leaving off always goes through soft start.
  // stop conditions
  assign stop_all = supply_low_s | input_high_s | ~enable_s | thermal_s;
  assign fault_trip = under_q.det & limit_s;

  // Main sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= buck_seq_pkg::ST_OFF;
    end else if (supply_low_s || !enable_s) begin
      state <= buck_seq_pkg::ST_OFF;
    end else if (stop_all && state != buck_seq_pkg::ST_LATCH) begin
      // Input overvoltage and heat stop switching but keep a latched trip.
      state <= buck_seq_pkg::ST_OFF;
    end else begin
      case (state)
        buck_seq_pkg::ST_OFF: begin
          state <= buck_seq_pkg::ST_SOFT;
        end
        buck_seq_pkg::ST_SOFT: begin
          if (fault_trip) begin
            state <= latch_mode ? buck_seq_pkg::ST_LATCH : buck_seq_pkg::ST_HICCUP;
          end else if (ss_cnt == SS_LAST) begin
            state <= buck_seq_pkg::ST_RUN;
          end
        end
        buck_seq_pkg::ST_RUN: begin
          if (fault_trip) begin
            state <= latch_mode ? buck_seq_pkg::ST_LATCH : buck_seq_pkg::ST_HICCUP;
          end
        end
        buck_seq_pkg::ST_HICCUP: begin
          if (hic_cnt == HIC_LAST) begin
            state <= buck_seq_pkg::ST_SOFT;
          end
        end
        buck_seq_pkg::ST_LATCH: begin
          state <= buck_seq_pkg::ST_LATCH;
        end
        default: begin
          state <= buck_seq_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Soft-start timer runs only in the soft state.
  // internal soft-start length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_cnt <= '0;
    end else if (state == buck_seq_pkg::ST_SOFT && ss_cnt != SS_LAST) begin
      ss_cnt <= ss_cnt + SCW'(1);
    end else if (state != buck_seq_pkg::ST_SOFT) begin
      ss_cnt <= '0;
    end
  end

  // Hiccup hold-off timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt <= '0;
    end else if (state == buck_seq_pkg::ST_HICCUP) begin
      hic_cnt <= hic_cnt + HCW'(1);
    end else begin
      hic_cnt <= '0;
    end
  end

  // Switching pauses on raw overvoltage but the sequencer keeps running.
  // overvoltage pause
  assign switching = (state == buck_seq_pkg::ST_SOFT || state == buck_seq_pkg::ST_RUN)
                     & ~over_s;

  // During soft start the on-time demand ramps by one cycle per period,
  // which bounds inrush without a separate reference DAC.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp <= '0;
    end else if (state != buck_seq_pkg::ST_SOFT && state != buck_seq_pkg::ST_RUN) begin
      ramp <= '0;
    end else if (period_end && ramp < demand) begin
      ramp <= ramp + PW'(1);
    end
  end
  assign eff_demand = (state == buck_seq_pkg::ST_SOFT && ramp < demand) ? ramp : demand;

  // Pulse width for the coming period.
  // minimum off-time cap
  assign cur_period = NOM + stretch;
  assign max_on = cur_period - MIN_OFF;
  assign off_cut = eff_demand >= max_on;
  assign on_len = (eff_demand < MIN_ON) ? '0 : (off_cut ? max_on : eff_demand);

  // Period counter restarts whenever switching is halted.
  // stretchable period timebase
  assign period_end = (pcnt == cur_period - PW'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt <= '0;
    end else if (!switching || period_end) begin
      pcnt <= '0;
    end else begin
      pcnt <= pcnt + PW'(1);
    end
  end

  // Width is frozen at period start so a demand write mid-period cannot
  // shorten a pulse below the minimum.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_on <= '0;
    end else if (pcnt == '0) begin
      cyc_on <= on_len;
    end
  end
  assign cur_on = (pcnt == '0) ? on_len : cyc_on;

  // Duty-over: each period with the off-time cut adds one cycle, else one
  // cycle is removed, so the period moves linearly between 1x and 4x.
  // period stretching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch <= '0;
    end else if (!switching) begin
      stretch <= '0;
    end else if (period_end) begin
      if (off_cut && stretch < STRETCH_MAX) begin
        stretch <= stretch + PW'(1);
      end else if (!off_cut && stretch != '0) begin
        stretch <= stretch - PW'(1);
      end
    end
  end

  // Complementary switch commands; both off while halted.
  // complementary drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
    end else begin
      high_side_on <= switching && (pcnt < cur_on);
      low_side_on <= switching && !(pcnt < cur_on);
    end
  end

  // Power-good pin is held low in every non-run state or output fault.
  // power-good drive
  assign power_fault = (state != buck_seq_pkg::ST_RUN) | over_q.det | under_q.det;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_ok_flag_oe_n <= 1'b0;
    end else begin
      output_ok_flag_oe_n <= ~power_fault;
    end
  end
  assign output_ok_flag_out = 1'b0;

  // APB slave: zero wait states, read data captured in the setup cycle.
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign addr_ok = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_PERIOD);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Control register, byte-lane writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demand <= `CTRL_RESET_DEMAND;
      latch_mode <= 1'b0;
    end else if (wr_access && paddr == `REG_CTRL) begin
      if (pstrb[0]) begin
        demand <= pwdata[`CTRL_DEMAND_LSB +: `CTRL_DEMAND_W];
      end
      if (pstrb[1]) begin
        latch_mode <= pwdata[`CTRL_LATCH_BIT];
      end
    end
  end

  // Read mux.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: begin
        next_rdata[`CTRL_DEMAND_LSB +: `CTRL_DEMAND_W] = demand;
        next_rdata[`CTRL_LATCH_BIT] = latch_mode;
      end
      `REG_STATUS: begin
        next_rdata[2:0] = state;
        next_rdata[3] = high_side_on;
        next_rdata[4] = low_side_on;
        next_rdata[5] = over_q.det;
        next_rdata[6] = under_q.det;
        next_rdata[7] = sync2[I_PGPIN];
        next_rdata[8] = power_fault;
        next_rdata[9] = stretch != '0;
      end
      `REG_PERIOD: begin
        next_rdata[PW-1:0] = cur_period;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end
endmodule : buck_seq_top

// file: buck_seq_partner.sv
`timescale 1ns/1ps
module buck_seq_partner (
  input wire logic [6:0] req,
  input wire logic high_side_on,
  input wire logic output_ok_flag_out,
  input wire logic output_ok_flag_oe_n,
  output logic supply_low_lockout,
  output logic input_high_lockout,
  output logic thermal_shutdown,
  output logic output_over_detect,
  output logic output_under_detect,
  output logic current_limit,
  output logic enable_high,
  output logic output_ok_flag_in
);
  // Comparator levels follow the bench's fault requests.
  assign {output_under_detect, output_over_detect} = req[4:3];
  assign {thermal_shutdown, input_high_lockout, supply_low_lockout} = req[2:0];
  assign enable_high = ~req[6];
  // A peak current limit can only trip while the high side conducts.
  assign current_limit = req[5] & high_side_on;
  // The pull-up wins unless the open drain pulls the line low.
  assign output_ok_flag_in = output_ok_flag_oe_n ? 1'b1 : output_ok_flag_out;
endmodule : buck_seq_partner

// file: buck_seq_monitor.sv
`timescale 1ns/1ps
module buck_seq_monitor #(
  parameter int NOM_PERIOD = 10,
  parameter int FILTER_CYCLES = 300,
  parameter int RELEASE_CYCLES = 2400
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_low_lockout,
  input wire logic input_high_lockout,
  input wire logic enable_high,
  input wire logic thermal_shutdown,
  input wire logic output_over_detect,
  input wire logic output_under_detect,
  input wire logic current_limit,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic output_ok_flag_oe_n
);
  logic stop_any;
  logic calm;
  logic [2:0] quiet_cnt;
  logic [2:0] calm_cnt;
  logic [15:0] ov_cnt;
  logic [15:0] clear_cnt;
  logic [7:0] hs_cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Stop causes, and calm meaning no fault input but overvoltage.
  assign stop_any = supply_low_lockout | input_high_lockout | thermal_shutdown | ~enable_high;
  assign calm = ~(stop_any | output_under_detect | current_limit);

  // Inputs pass a two-flop sync, so a few calm cycles prove the core sees calm.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 3'h0;
      calm_cnt <= 3'h0;
    end else begin
      quiet_cnt <= (!calm || output_over_detect) ? 3'h0 : quiet_cnt + {2'h0, quiet_cnt != 3'h7};
      calm_cnt <= !calm ? 3'h0 : calm_cnt + {2'h0, calm_cnt != 3'h7};
    end
  end

  // Run lengths of overvoltage, of a clean output and of a high-side pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cnt <= 16'h0000;
      clear_cnt <= 16'h0000;
      hs_cnt <= 8'h00;
    end else begin
      ov_cnt <= output_over_detect ? ov_cnt + {15'h0, ov_cnt != 16'hFFFF} : 16'h0000;
      clear_cnt <= (output_over_detect | output_under_detect) ? 16'h0000 :
        clear_cnt + {15'h0, clear_cnt != 16'hFFFF};
      hs_cnt <= high_side_on ? hs_cnt + 8'h01 : 8'h00;
    end
  end

  sequence s_stop_held;
    stop_any [*6];
  endsequence
  sequence s_hs_fall;
    $fell(high_side_on) ##0 (quiet_cnt >= 3'h4);
  endsequence

  property p_stop_safe;
    s_stop_held |-> !high_side_on && !low_side_on && !output_ok_flag_oe_n;
  endproperty
  a_stop_safe: assert property (p_stop_safe) else $error("switching during stop");
  property p_min_on;
    $rose(high_side_on) && quiet_cnt >= 3'h4 |=> high_side_on;
  endproperty
  a_min_on: assert property (p_min_on) else $error("high pulse too short");
  property p_min_off;
    $fell(high_side_on) |-> !high_side_on [*3];
  endproperty
  a_min_off: assert property (p_min_off) else $error("off time too short");
  property p_ls_follow;
    s_hs_fall |-> low_side_on [*2];
  endproperty
  a_ls_follow: assert property (p_ls_follow) else $error("low side not on");
  property p_max_on;
    high_side_on |-> hs_cnt < 4 * NOM_PERIOD - 3;
  endproperty
  a_max_on: assert property (p_max_on) else $error("high side on too long");
  property p_pg_hold;
    output_ok_flag_oe_n && output_over_detect && ov_cnt < FILTER_CYCLES && calm_cnt == 3'h7
      |=> output_ok_flag_oe_n;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good fell early");
  property p_pg_trip;
    ov_cnt >= FILTER_CYCLES + 6 |-> !output_ok_flag_oe_n;
  endproperty
  a_pg_trip: assert property (p_pg_trip) else $error("power good not low");
  property p_pg_release;
    $rose(output_ok_flag_oe_n) |-> clear_cnt >= RELEASE_CYCLES;
  endproperty
  a_pg_release: assert property (p_pg_release) else $error("power good early");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmapped;
    psel && penable && paddr > 12'h008 |-> pslverr && (pwrite || prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule : buck_seq_monitor

bind buck_seq_top buck_seq_monitor #(.NOM_PERIOD(NOM_PERIOD), .FILTER_CYCLES(FILTER_CYCLES),
  .RELEASE_CYCLES(RELEASE_CYCLES)) buck_seq_monitor_i (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .supply_low_lockout, .input_high_lockout,
  .enable_high, .thermal_shutdown, .output_over_detect, .output_under_detect, .current_limit,
  .high_side_on, .low_side_on, .output_ok_flag_oe_n);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int FLT = 8;
  localparam int REL = 16;
  localparam int SS = 50;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [6:0] req = 7'h00;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, rerr, high_side_on, low_side_on, current_limit, enable_high;
  logic supply_low_lockout, input_high_lockout, thermal_shutdown;
  logic output_over_detect, output_under_detect;
  logic output_ok_flag_in, output_ok_flag_out, output_ok_flag_oe_n;
  int n_mismatch = 0;
  int tests_run = 0;

  buck_seq_top #(.NOM_PERIOD(10), .SS_CYCLES(SS), .HICCUP_CYCLES(60), .FILTER_CYCLES(FLT),
    .RELEASE_CYCLES(REL)) buck_seq_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .supply_low_lockout, .input_high_lockout,
    .enable_high, .thermal_shutdown, .output_over_detect, .output_under_detect, .current_limit,
    .high_side_on, .low_side_on, .output_ok_flag_in, .output_ok_flag_out, .output_ok_flag_oe_n);
  buck_seq_partner buck_seq_partner_i (.req, .high_side_on, .output_ok_flag_out,
    .output_ok_flag_oe_n, .supply_low_lockout, .input_high_lockout, .thermal_shutdown,
    .output_over_detect, .output_under_detect, .current_limit, .enable_high, .output_ok_flag_in);

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One bus transfer; request held until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the state field; the watchdog and a poll limit bound the wait.
  task automatic st(input buck_seq_pkg::seq_state_t s);
    int n = 0;
    apb(1'b0, 12'h004, 32'h0);
    while (rdv[2:0] !== s && n < 400) begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end
    chk(32'(rdv[2:0]), 32'(s));
  endtask : st

  // Measures one full high pulse and the low span after it.
  task automatic meas(output int on, output int off);
    on = 0;
    off = 0;
    while (high_side_on !== 1'b0 && on < 200) begin
      @(posedge pclk);
      on++;
    end
    while (high_side_on !== 1'b1 && off < 200) begin
      @(posedge pclk);
      off++;
    end
    on = 0;
    off = 0;
    while (high_side_on === 1'b1 && on < 200) begin
      @(posedge pclk);
      on++;
    end
    while (high_side_on === 1'b0 && off < 200) begin
      @(posedge pclk);
      off++;
    end
  endtask : meas

  task automatic hold(input int b, input int n);
    @(posedge pclk);
    req[b] <= 1'b1;
    cyc(n);
    req[b] <= 1'b0;
  endtask : hold

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // Cuts a hang short well beyond the expected run length.
  initial begin
    cyc(60000);
    n_mismatch++;
    results();
  end

  initial begin
    int on;
    int off;
    cyc(4);
    chk(32'({high_side_on, low_side_on, output_ok_flag_oe_n}), 32'h0);
    cyc(4);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rdv, 32'h0);
    st(buck_seq_pkg::ST_SOFT);
    chk(32'(output_ok_flag_in), 32'h0);
    st(buck_seq_pkg::ST_RUN);
    chk(32'(output_ok_flag_in), 32'h1);
    $display("reset test done");
    for (int d = 1; d <= 6; d++) begin
      apb(1'b1, 12'h000, 32'(d));
      meas(on, off);
      meas(on, off);
      chk(32'(on), d < 2 ? 32'h0 : 32'(d));
      if (d > 1) chk(32'(off), 32'(10 - d));
    end
    $display("pwm test done");
    apb(1'b1, 12'h00C, 32'hFF);
    chk(32'(rerr), 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rdv[30:0], rerr}, 32'h1);
    apb(1'b1, 12'h000, 32'hFF);
    cyc(1500);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdv, 32'h28);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(rdv[9]), 32'h1);
    meas(on, off);
    chk(32'(on), 32'h25);
    chk(32'(off), 32'h3);
    apb(1'b1, 12'h000, 32'h4);
    cyc(1500);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdv, 32'hA);
    $display("stretch test done");
    @(posedge pclk);
    req[3] <= 1'b1;
    cyc(5);
    chk(32'({high_side_on, output_ok_flag_in}), 32'h1);
    cyc(FLT + 4);
    chk(32'(output_ok_flag_in), 32'h0);
    req[3] <= 1'b0;
    cyc(REL - 4);
    chk(32'(output_ok_flag_in), 32'h0);
    cyc(12);
    chk(32'(output_ok_flag_in), 32'h1);
    meas(on, off);
    chk(32'(on), 32'h4);
    hold(4, FLT - 3);
    hold(4, FLT - 3);
    cyc(4);
    chk(32'(output_ok_flag_in), 32'h1);
    hold(4, FLT + 6);
    chk(32'(output_ok_flag_in), 32'h0);
    cyc(REL - 4);
    chk(32'(output_ok_flag_in), 32'h0);
    cyc(12);
    chk(32'(output_ok_flag_in), 32'h1);
    $display("output monitor test done");
    req[5:4] <= 2'h3;
    st(buck_seq_pkg::ST_HICCUP);
    chk(32'({high_side_on, output_ok_flag_in}), 32'h0);
    cyc(30);
    st(buck_seq_pkg::ST_HICCUP);
    req[5:4] <= 2'h0;
    st(buck_seq_pkg::ST_SOFT);
    st(buck_seq_pkg::ST_RUN);
    apb(1'b1, 12'h000, 32'h104);
    req[5:4] <= 2'h3;
    st(buck_seq_pkg::ST_LATCH);
    req[5:4] <= 2'h0;
    cyc(200);
    st(buck_seq_pkg::ST_LATCH);
    hold(2, 8);
    cyc(6);
    st(buck_seq_pkg::ST_LATCH);
    req[6] <= 1'b1;
    st(buck_seq_pkg::ST_OFF);
    chk(32'(output_ok_flag_in), 32'h0);
    req[6] <= 1'b0;
    st(buck_seq_pkg::ST_SOFT);
    cyc(SS - 15);
    st(buck_seq_pkg::ST_SOFT);
    st(buck_seq_pkg::ST_RUN);
    apb(1'b1, 12'h000, 32'h4);
    $display("protection test done");
    for (int i = 0; i < 3; i++) begin
      req[i] <= 1'b1;
      cyc(8);
      chk(32'({high_side_on, low_side_on, output_ok_flag_in}), 32'h0);
      st(buck_seq_pkg::ST_OFF);
      req[i] <= 1'b0;
      st(buck_seq_pkg::ST_SOFT);
      st(buck_seq_pkg::ST_RUN);
    end
    $display("stop test done");
    results();
  end
endmodule : tb_top
